// file: logic/fault_latch_pkg.sv
// Constants and carrier types for the stepper fault protection latch.
package fault_latch_pkg;
   localparam int unsigned CLK_PERIOD_PS      = 4000;
   localparam int unsigned BLANK_TIME_PS      = 1250000;
   localparam int unsigned BLANK_CYCLES       = (BLANK_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned ENABLE_SETTLE_PS   = 30000000;
   localparam int unsigned ENABLE_SETTLE_CYC  = ENABLE_SETTLE_PS / CLK_PERIOD_PS;
   localparam int unsigned OPEN_MIN_MA        = 1400;
   localparam int unsigned OVERCURRENT_MA     = 5000;
   localparam int unsigned OVERHEAT_DEGC      = 144;
   localparam logic [1:0]  RESET_TYPE_VALUE   = 2'h0;

   // Fault-type output levels: open ~10 mV, overcurrent ~2.5 V, overheat ~3.3 V.
   typedef enum logic [1:0] {
      FAULT_NONE        = 2'b00,
      FAULT_OPEN        = 2'b01,
      FAULT_OVERCURRENT = 2'b10,
      FAULT_OVERHEAT    = 2'b11
   } fault_type_t;

   typedef enum logic [1:0] {
      RST_IDLE = 2'b00,
      RST_LOW  = 2'b01,
      RST_DONE = 2'b10
   } rst_seq_t;

   typedef struct packed {
      logic open_det;
      logic overcurrent;
      logic overheat;
   } detect_t;
endpackage : fault_latch_pkg

// file: logic/stepper_fault_protection_latch.sv
// Fault detection latch, reporting and output shutdown of a stepper driver.
// Notes on behaviour
// R1 - Fault-type output gives one of three levels naming open, overcurrent or overheat.
// R2 - Any detection latches and holds phase outputs off until a reset.
// R3 - Latch clears on power-on reset or system_reset_n going high, low, high.
// R4 - Open terminal declared when no flyback current is seen in PWM off time.
// R5 - Open detection only trusted when motor current is at least about 1.4 A.
// R6 - Chopping within 30 us after enable rises may trip open detection.
// R7 - Controller should avoid chopping within 30 us after raising enable.
// R8 - Current sensing is ignored for 1.25 us at each PWM period start; the code blanks only the overcurrent comparator, not open detection.
// R9 - Blanking applies only inside PWM periods, not to the initial current rise; the code ignores overcurrent until the first PWM period start.
// R10 - Overcurrent trips at about 5.0 A phase current.
// R11 - Overcurrent counted only after the 1.25 us dead time of each PWM period.
// R12 - Overheat trips on substrate temperature, about 144 C.
// R13 - Excitation monitor output toggles at a rate set by excitation mode.
// R14 - Any-fault flag is open drain, pulled low while any fault is latched.
// R15 - Fault type holds the first fault; flag stays asserted until reset.
module stepper_fault_protection_latch
   import fault_latch_pkg::*;
#(
   parameter int unsigned BLANK_CYC = BLANK_CYCLES
) (
   // Clock and power-on reset.
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Host control pins, asynchronous to i_clk.
   input  wire logic        i_system_reset_n,
   input  wire logic        i_enable,
   // Power stage sense, asynchronous comparator levels.
   input  wire logic        i_pwm_period_start,
   input  wire logic        i_pwm_off,
   input  wire logic        i_flyback_seen,
   input  wire logic        i_current_above_open_min,
   input  wire logic        i_overcurrent_cmp,
   input  wire logic        i_substrate_overheat,
   input  wire logic        i_excitation_step,
   // Fault reporting and phase gating.
   output logic             o_phase_enable,
   output logic             o_any_fault_flag_n_out,
   output logic             o_any_fault_flag_n_oe,
   output fault_type_t      o_fault_type_level,
   output logic             o_excitation_monitor_out
);
   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   localparam int NSYNC = 9;
   // The blank counter is 12 bits wide and must load a non-zero interval.
   if (BLANK_CYC < 1 || BLANK_CYC > 4095) begin : g_blank_chk
      $error("BLANK_CYC out of range");
   end
   logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg;
   logic [NSYNC-1:0] s1_next, s2_next, s3_next;
   always_comb begin
      s1_next = {i_system_reset_n, i_enable, i_pwm_period_start, i_pwm_off, i_flyback_seen,
                 i_current_above_open_min, i_overcurrent_cmp, i_substrate_overheat,
                 i_excitation_step};
      s2_next = s1_reg;
      s3_next = s2_reg;
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
      end
   end
   logic    rstn_s, en_s, pstart_s, poff_s, step_s, step_d, pstart_d;
   detect_t det_s;
   logic    fly_s, above_s;
   assign rstn_s   = s2_reg[8];
   assign en_s     = s2_reg[7];
   assign pstart_s = s2_reg[6];
   assign poff_s   = s2_reg[5];
   assign fly_s    = s2_reg[4];
   assign above_s  = s2_reg[3];
   assign step_s   = s2_reg[0];
   assign step_d   = s3_reg[0];
   assign pstart_d = s3_reg[6];
   assign det_s.overcurrent = s2_reg[2];
   assign det_s.overheat    = s2_reg[1];
   // Open detect trusted only above the minimum current level.
   assign det_s.open_det    = en_s && poff_s && above_s && !fly_s; // see R4, R5

   // ****************************************************************
   // Reset sequence, blanking and fault latch
   // ****************************************************************
   rst_seq_t    seq_reg, seq_next;
   logic [11:0] blank_reg, blank_next;
   logic        in_pwm_reg, in_pwm_next;
   fault_type_t type_reg, type_next;
   logic        mon_reg, mon_next;
   logic        clear_pulse, sense_ok, open_hit, oc_hit, heat_hit;
   logic        phase_next, flag_oe_next;

   always_comb begin
      seq_next    = seq_reg;
      clear_pulse = 1'b0;
      case (seq_reg)
         RST_IDLE: begin
            if (rstn_s) begin
               seq_next = RST_DONE;
            end
         end
         RST_DONE: begin
            if (!rstn_s) begin
               seq_next = RST_LOW;
            end
         end
         RST_LOW: begin
            if (rstn_s) begin
               seq_next    = RST_DONE;
               clear_pulse = 1'b1; // see R3
            end
         end
         default: seq_next = RST_IDLE;
      endcase
   end

   always_comb begin
      blank_next  = blank_reg;
      in_pwm_next = in_pwm_reg;
      if (!en_s) begin
         in_pwm_next = 1'b0;
      end else if (pstart_s && !pstart_d) begin
         // Blanking arms only on a PWM period start, never on the first rise.
         in_pwm_next = 1'b1; // see R9
         blank_next  = 12'(BLANK_CYC); // see R8
      end else if (blank_reg != 12'h000) begin
         blank_next = blank_reg - 12'h001;
      end
   end

   always_comb begin
      sense_ok = in_pwm_reg && (blank_reg == 12'h000); // see R8, R11
      open_hit = det_s.open_det; // see R4, R5, R6
      oc_hit   = sense_ok && det_s.overcurrent; // see R10, R11
      heat_hit = det_s.overheat; // see R12
      type_next = type_reg;
      // A fault seen in the clearing cycle still latches, so a live fault never
      // lets the phases conduct for even one cycle.
      if (clear_pulse || type_reg == FAULT_NONE) begin
         // Overheat outranks the others when two arrive together.
         if (heat_hit) begin
            type_next = FAULT_OVERHEAT; // see R1, R15
         end else if (oc_hit) begin
            type_next = FAULT_OVERCURRENT; // see R1, R15
         end else if (open_hit) begin
            type_next = FAULT_OPEN; // see R1, R15
         end else if (clear_pulse) begin
            type_next = FAULT_NONE; // see R3
         end
      end
      phase_next   = en_s && (type_next == FAULT_NONE); // see R2
      flag_oe_next = (type_next == FAULT_NONE); // see R14
      mon_next = (step_s && !step_d) ? !mon_reg : mon_reg; // see R13
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         seq_reg    <= RST_IDLE;
         blank_reg  <= 12'h000;
         in_pwm_reg <= 1'b0;
         type_reg   <= FAULT_NONE;
         mon_reg    <= 1'b0;
      end else begin
         seq_reg    <= seq_next;
         blank_reg  <= blank_next;
         in_pwm_reg <= in_pwm_next;
         type_reg   <= type_next; // see R2
         mon_reg    <= mon_next;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   logic phase_reg, flag_oe_reg;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         phase_reg   <= 1'b0;
         flag_oe_reg <= 1'b1;
      end else begin
         phase_reg   <= phase_next; // see R2
         flag_oe_reg <= flag_oe_next; // see R14
      end
   end
   assign o_phase_enable           = phase_reg;
   assign o_any_fault_flag_n_out   = 1'b0;
   assign o_any_fault_flag_n_oe    = flag_oe_reg;
   assign o_fault_type_level       = type_reg;
   assign o_excitation_monitor_out = mon_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence reset_low_s;
      seq_reg == RST_LOW && !rstn_s;
   endsequence
   sequence reset_pulse_s;
      reset_low_s ##1 (seq_reg == RST_LOW && rstn_s);
   endsequence
   latch_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // see R2
      (type_reg != FAULT_NONE && !clear_pulse) |=> (type_reg == $past(type_reg)))
      else $error("fault type changed without reset");
   phase_off_a: assert property (@(posedge i_clk) disable iff (i_rst) // see R2
      (type_reg != FAULT_NONE) |-> !phase_reg)
      else $error("phase on while fault latched");
   flag_low_a: assert property (@(posedge i_clk) disable iff (i_rst) // see R14
      (type_reg != FAULT_NONE) |-> !flag_oe_reg)
      else $error("fault flag released while latched");
   reset_clear_a: assert property (@(posedge i_clk) disable iff (i_rst) // see R3
      reset_pulse_s ##0 (!heat_hit && !oc_hit && !open_hit) |=> type_reg == FAULT_NONE)
      else $error("reset pulse did not clear fault");
   blank_oc_a: assert property (@(posedge i_clk) disable iff (i_rst) // see R11
      (blank_reg != 12'h000 && type_reg == FAULT_NONE && !heat_hit && !open_hit)
      |=> type_reg != FAULT_OVERCURRENT)
      else $error("overcurrent taken during blanking");
   oc_trip_a: assert property (@(posedge i_clk) disable iff (i_rst) // see R10
      (type_reg == FAULT_NONE && oc_hit && !heat_hit && !clear_pulse)
      |=> type_reg == FAULT_OVERCURRENT)
      else $error("overcurrent not latched");
   heat_trip_a: assert property (@(posedge i_clk) disable iff (i_rst) // see R12
      (type_reg == FAULT_NONE && heat_hit && !clear_pulse) |=> type_reg == FAULT_OVERHEAT)
      else $error("overheat not latched");
   open_trip_a: assert property (@(posedge i_clk) disable iff (i_rst) // see R4
      (type_reg == FAULT_NONE && open_hit && !heat_hit && !oc_hit && !clear_pulse)
      |=> type_reg == FAULT_OPEN)
      else $error("open terminal not latched");
   blank_len_a: assert property (@(posedge i_clk) disable iff (i_rst) // see R8
      (en_s && pstart_s && !pstart_d) |=> blank_reg == 12'(BLANK_CYC))
      else $error("blank interval wrong length");
   monitor_a: assert property (@(posedge i_clk) disable iff (i_rst) // see R13
      (step_s && !step_d) |=> mon_reg != $past(mon_reg))
      else $error("monitor did not toggle");
endmodule : stepper_fault_protection_latch

// file: dv/host_ctrl_model.sv
// Behavioural host controller that drives the reset and enable pins of the latch.
module host_ctrl_model
   import fault_latch_pkg::*;
(
   // Clock.
   input  wire logic i_clk,
   // Host pins.
   output logic      o_system_reset_n,
   output logic      o_enable
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_system_reset_n = 1'b1;
      o_enable         = 1'b0;
   end

   // Reset pin idles high, is pulled low for a few cycles, then returns high.
   task automatic pulse_reset();
      @(posedge i_clk);
      #1 o_system_reset_n = 1'b0;
      repeat (5) @(posedge i_clk);
      #1 o_system_reset_n = 1'b1;
   endtask : pulse_reset

   // After enable rises the host holds off any chopping for the settle window.
   // A false open-terminal trip would otherwise be legal device behaviour.
   task automatic set_enable(input logic value);
      @(posedge i_clk);
      #1 o_enable = value;
      if (value) begin
         repeat (ENABLE_SETTLE_CYC) @(posedge i_clk);
         #1;
      end
   endtask : set_enable
endmodule : host_ctrl_model

// file: dv/stepper_fault_protection_latch_tb.sv
// Self-checking testbench for the stepper fault protection latch.
module stepper_fault_protection_latch_tb;
   import fault_latch_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned BLANK_T = 20;

   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        sys_rst_n;
   logic        enable;
   logic        period_start = 1'b0;
   logic        pwm_off = 1'b0;
   logic        flyback = 1'b0;
   logic        above_min = 1'b0;
   logic        oc = 1'b0;
   logic        overheat = 1'b0;
   logic        exc_step = 1'b0;
   logic        phase_en;
   logic        flag_out;
   logic        flag_oe;
   logic        monitor;
   fault_type_t fault_type;
   wire logic   flag_pin = flag_oe ? 1'b1 : flag_out;
   int          err_count = 0;
   int          compares = 0;
   int          cycles = 0;

   always #2 i_clk = ~i_clk;

   stepper_fault_protection_latch #(.BLANK_CYC(BLANK_T)) DUT (
      .i_clk(i_clk), .i_rst(i_rst), .i_system_reset_n(sys_rst_n), .i_enable(enable),
      .i_pwm_period_start(period_start), .i_pwm_off(pwm_off), .i_flyback_seen(flyback),
      .i_current_above_open_min(above_min), .i_overcurrent_cmp(oc),
      .i_substrate_overheat(overheat), .i_excitation_step(exc_step),
      .o_phase_enable(phase_en), .o_any_fault_flag_n_out(flag_out),
      .o_any_fault_flag_n_oe(flag_oe), .o_fault_type_level(fault_type),
      .o_excitation_monitor_out(monitor));

   host_ctrl_model host (.i_clk(i_clk), .o_system_reset_n(sys_rst_n), .o_enable(enable));

   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : step

   task automatic cmp_type(input fault_type_t got, input fault_type_t exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t type got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_type

   task automatic cmp_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t bit got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_bit

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   // The run needs about 8000 cycles; the ceiling leaves ample margin.
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         finish_test();
      end
   end

   initial begin
      step(16);
      i_rst = 1'b0;
      step(1);
      cmp_type(fault_type, FAULT_NONE);
      cmp_bit(flag_oe, 1'b1);
      host.set_enable(1'b1);
      cmp_bit(phase_en, 1'b1);
      oc = 1'b1;
      step(8);
      cmp_type(fault_type, FAULT_NONE);
      period_start = 1'b1;
      step(BLANK_T - 6);
      cmp_type(fault_type, FAULT_NONE);
      step(16);
      cmp_type(fault_type, FAULT_OVERCURRENT);
      cmp_bit(phase_en, 1'b0);
      cmp_bit(flag_pin, 1'b0);
      oc = 1'b0;
      period_start = 1'b0;
      overheat = 1'b1;
      step(8);
      cmp_type(fault_type, FAULT_OVERCURRENT);
      overheat = 1'b0;
      host.pulse_reset();
      step(8);
      cmp_type(fault_type, FAULT_NONE);
      cmp_bit(flag_pin, 1'b1);
      cmp_bit(phase_en, 1'b1);
      overheat = 1'b1;
      step(6);
      cmp_type(fault_type, FAULT_OVERHEAT);
      overheat = 1'b0;
      step(20);
      cmp_type(fault_type, FAULT_OVERHEAT);
      cmp_bit(flag_pin, 1'b0);
      cmp_bit(phase_en, 1'b0);
      i_rst = 1'b1;
      step(2);
      i_rst = 1'b0;
      step(1);
      cmp_type(fault_type, FAULT_NONE);
      pwm_off = 1'b1;
      step(8);
      cmp_type(fault_type, FAULT_NONE);
      above_min = 1'b1;
      flyback = 1'b1;
      step(8);
      cmp_type(fault_type, FAULT_NONE);
      flyback = 1'b0;
      step(6);
      cmp_type(fault_type, FAULT_OPEN);
      cmp_bit(phase_en, 1'b0);
      pwm_off = 1'b0;
      for (int i = 0; i < 3; i++) begin
         exc_step = 1'b1;
         step(4);
         exc_step = 1'b0;
         step(4);
      end
      cmp_bit(monitor, 1'b1);
      finish_test();
   end
endmodule : stepper_fault_protection_latch_tb
